//--- logic/xpc_pkg.sv
`default_nettype none
package xpc_pkg;
  localparam int NUM_OUT = 16;
  localparam int NUM_IN  = 16;
  localparam int SEL_W   = 4;
  localparam int SLOT_W  = 5;
  localparam int SR_W    = NUM_OUT * SLOT_W;
  localparam int EN_POS  = 4;
  localparam int XB_W    = NUM_OUT * NUM_IN;

  typedef struct packed {
    logic             cs_n;
    logic             upd_n;
    logic             mode;
    logic             lclk;
    logic             sin;
    logic [SEL_W-1:0] addr;
    logic [SLOT_W-1:0] data;
  } xpc_pins_t;

  typedef struct packed {
    xpc_pins_t         s1;
    xpc_pins_t         s2;
    logic              lclk_prev;
    logic [SR_W-1:0]   rank2;
    logic [XB_W-1:0]   src_en;
  } xpc_state_t;

  // Idle pin levels, so leaving reset never looks like an update
  localparam xpc_pins_t PINS_RST = '{cs_n:  1'b1,
                                     upd_n: 1'b1,
                                     mode:  1'b0,
                                     lclk:  1'b1,
                                     sin:   1'b0,
                                     addr:  4'h0,
                                     data:  5'h00};
endpackage : xpc_pkg
`default_nettype wire

//--- logic/xpc_loader.sv
`default_nettype none
module xpc_loader
  import xpc_pkg::*;
(
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            rstn,
  // Load control pins
  input  wire logic            chip_sel_n,
  input  wire logic            update_n,
  input  wire logic            load_mode_select,
  input  wire logic            load_clk,
  input  wire logic            serial_in,
  // Parallel slot data
  input  wire logic            select_bit0,
  input  wire logic            select_bit1,
  input  wire logic            select_bit2,
  input  wire logic            select_bit3,
  input  wire logic            output_enable_bit,
  input  wire logic            out_addr_bit0,
  input  wire logic            out_addr_bit1,
  input  wire logic            out_addr_bit2,
  input  wire logic            out_addr_bit3,
  // Chain output
  output logic                 serial_out,
  // Switch array controls
  output logic [SR_W-1:0]      route_image,
  output logic [XB_W-1:0]      src_enable
);

  xpc_pins_t        pins;
  xpc_state_t       st_q;
  xpc_state_t       st_d;
  logic [1:0]       rst_sync_q;
  logic             rst;
  logic [SR_W-1:0]  sr_q;
  logic [SR_W-1:0]  sr_d;
  logic             shift_fire;
  logic             par_fire;
  logic             follow;

  function automatic logic [XB_W-1:0] decode_image(
    input logic [SR_W-1:0] img
  );
    logic [XB_W-1:0] v;
    logic [SLOT_W-1:0] slot;
    v = '0;
    for (int o = 0; o < NUM_OUT; o++)
    begin
      slot = img[o*SLOT_W +: SLOT_W];
      if (slot[EN_POS])
      begin
        v[o*NUM_IN + int'(slot[SEL_W-1:0])] = 1'b1;
      end
    end
    return v;
  endfunction : decode_image

  // Count of enabled slots, one active source each
  function automatic int count_enabled(
    input logic [SR_W-1:0] img
  );
    int n;
    n = 0;
    for (int o = 0; o < NUM_OUT; o++)
    begin
      if (img[o*SLOT_W + EN_POS])
      begin
        n++;
      end
    end
    return n;
  endfunction : count_enabled

  assign pins = '{cs_n:  chip_sel_n,
                  upd_n: update_n,
                  mode:  load_mode_select,
                  lclk:  load_clk,
                  sin:   serial_in,
                  addr:  {out_addr_bit3, out_addr_bit2,
                          out_addr_bit1, out_addr_bit0},
                  data:  {output_enable_bit, select_bit3, select_bit2,
                          select_bit1, select_bit0}};

  // Async assert, synchronous release
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_sync_q <= 2'b11;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b0};
    end
  end
  assign rst = rst_sync_q[1] | !rstn;

  // Load strobes from second sync stage; serial shift also uses lclk_prev to see the fall
  assign shift_fire = !st_q.s2.cs_n && !st_q.s2.mode
                      && st_q.lclk_prev && !st_q.s2.lclk;
  assign par_fire   = !st_q.s2.cs_n && st_q.s2.mode
                      && !st_q.s2.lclk;
  assign follow     = !st_q.s2.cs_n && !st_q.s2.upd_n;

  always_comb
  begin
    st_d = st_q;
    st_d.s1 = pins;
    st_d.s2 = st_q.s1;
    st_d.lclk_prev = st_q.s2.lclk;
    if (follow)
    begin
      st_d.rank2 = sr_q;
    end
    st_d.src_en = decode_image(st_q.rank2);
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= '{s1: PINS_RST, s2: PINS_RST, lclk_prev: PINS_RST.lclk,
                rank2: '0, src_en: '0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // No reset here: image survives reset and powers up unknown
  always_comb
  begin
    sr_d = sr_q;
    if (shift_fire)
    begin
      sr_d = {sr_q[SR_W-2:0], st_q.s2.sin};
    end
    else if (par_fire)
    begin
      sr_d[int'(st_q.s2.addr)*SLOT_W +: SLOT_W] = st_q.s2.data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    sr_q <= sr_d;
  end

  assign serial_out  = sr_q[SR_W-1];
  assign route_image = st_q.rank2;
  assign src_enable  = st_q.src_en;

  sequence s_fall;
    st_q.lclk_prev && !st_q.s2.lclk;
  endsequence

  sequence s_serial_shift;
    !st_q.s2.cs_n && !st_q.s2.mode ##0 s_fall;
  endsequence

  sequence s_update;
    !st_q.s2.cs_n && !st_q.s2.upd_n;
  endsequence

  sequence s_par_idle;
    !st_q.s2.cs_n && st_q.s2.mode && st_q.s2.lclk;
  endsequence

  a_cs_hold_image: assert property (
    @(posedge core_clk) disable iff (rst)
    st_q.s2.cs_n |=> $stable(sr_q))
    else $error("image changed while deselected");

  a_serial_shift_in: assert property (
    @(posedge core_clk) disable iff (rst)
    s_serial_shift |=> sr_q[0] == $past(st_q.s2.sin))
    else $error("serial bit not shifted in");

  a_serial_out_next: assert property (
    @(posedge core_clk) disable iff (rst)
    s_serial_shift |=> serial_out == $past(sr_q[SR_W-2]))
    else $error("serial_out did not advance by one");

  a_par_slot_write: assert property (
    @(posedge core_clk) disable iff (rst)
    par_fire |=> sr_q[int'($past(st_q.s2.addr))*SLOT_W +: SLOT_W]
                 == $past(st_q.s2.data))
    else $error("parallel slot not written");

  a_par_msb_out: assert property (
    @(posedge core_clk) disable iff (rst)
    s_par_idle |=> serial_out == $past(serial_out))
    else $error("serial_out moved with no parallel write");

  a_rank_follow: assert property (
    @(posedge core_clk) disable iff (rst)
    follow |=> route_image == $past(sr_q))
    else $error("second rank did not follow image");

  a_rank_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    !follow |=> $stable(route_image))
    else $error("second rank moved without update");

  a_reset_clear: assert property (
    @(posedge core_clk) disable iff (!rstn)
    rst_sync_q[1] |-> route_image == '0 && src_enable == '0)
    else $error("reset did not clear second rank");

  a_reset_keep: assert property (
    @(posedge core_clk) disable iff (!rstn)
    rst_sync_q[1] && st_q.s2.cs_n |=> $stable(sr_q))
    else $error("reset disturbed the image");

  a_decode_match: assert property (
    @(posedge core_clk) disable iff (rst)
    ##1 src_enable == decode_image($past(route_image)))
    else $error("decoder output mismatch");

  a_cs_hold_rank: assert property (
    @(posedge core_clk) disable iff (rst)
    st_q.s2.cs_n |=> $stable(route_image))
    else $error("second rank moved while deselected");

  a_cs_no_strobe: assert property (
    @(posedge core_clk) disable iff (rst)
    st_q.s2.cs_n |-> !shift_fire && !par_fire && !follow)
    else $error("strobe fired while deselected");

  a_par_clk_high: assert property (
    @(posedge core_clk) disable iff (rst)
    s_par_idle |=> $stable(sr_q))
    else $error("parallel write with load clock high");

  a_par_only_write: assert property (
    @(posedge core_clk) disable iff (rst)
    st_q.s2.mode && !par_fire |=> $stable(sr_q))
    else $error("image changed in parallel mode without write");

  a_serial_edge_only: assert property (
    @(posedge core_clk) disable iff (rst)
    !st_q.s2.mode && !shift_fire |=> $stable(sr_q))
    else $error("image changed in serial mode without a fall");

  a_shift_whole: assert property (
    @(posedge core_clk) disable iff (rst)
    s_serial_shift |=> sr_q[SR_W-1:1] == $past(sr_q[SR_W-2:0]))
    else $error("shift register did not move by one");

  a_update_decode: assert property (
    @(posedge core_clk) disable iff (rst)
    s_update |-> ##2 src_enable == decode_image($past(sr_q, 2)))
    else $error("update did not reach all decoders");

  // No disable here: the clear must show while reset is held
  a_reset_rank_now: assert property (
    @(posedge core_clk)
    !rstn |-> route_image == '0)
    else $error("second rank not cleared in reset");

  a_reset_dec_now: assert property (
    @(posedge core_clk)
    !rstn |-> src_enable == '0)
    else $error("decoders not cleared in reset");

  a_idle_after_rst: assert property (
    @(posedge core_clk) disable iff (!rstn)
    rst_sync_q[1] |-> st_q.s2.cs_n && st_q.s2.upd_n)
    else $error("reset left a false update pending");

  a_out0_off: assert property (
    @(posedge core_clk) disable iff (rst)
    !route_image[EN_POS] |=> src_enable[NUM_IN-1:0] == '0)
    else $error("disabled output 0 has a source");

  a_out0_one: assert property (
    @(posedge core_clk) disable iff (rst)
    route_image[EN_POS] |=> $onehot(src_enable[NUM_IN-1:0]))
    else $error("enabled output 0 lacks one source");

  a_out8_off: assert property (
    @(posedge core_clk) disable iff (rst)
    !route_image[8*SLOT_W+EN_POS]
    |=> src_enable[8*NUM_IN +: NUM_IN] == '0)
    else $error("disabled output 8 has a source");

  a_out8_one: assert property (
    @(posedge core_clk) disable iff (rst)
    route_image[8*SLOT_W+EN_POS]
    |=> $onehot(src_enable[8*NUM_IN +: NUM_IN]))
    else $error("enabled output 8 lacks one source");

  a_out15_off: assert property (
    @(posedge core_clk) disable iff (rst)
    !route_image[SR_W-1] |=> src_enable[XB_W-1 -: NUM_IN] == '0)
    else $error("disabled output 15 has a source");

  a_out15_one: assert property (
    @(posedge core_clk) disable iff (rst)
    route_image[SR_W-1] |=> $onehot(src_enable[XB_W-1 -: NUM_IN]))
    else $error("enabled output 15 lacks one source");

  // Shared inputs still give one source per enabled output
  a_multicast_cnt: assert property (
    @(posedge core_clk) disable iff (rst)
    1'b1 |=> $countones(src_enable)
             == count_enabled($past(route_image)))
    else $error("source count differs from enabled outputs");

endmodule : xpc_loader
`default_nettype wire

//--- testbench/xpc_host.sv
`default_nettype none
module xpc_host
  import xpc_pkg::*;
(
  // Clock
  input  wire logic     core_clk,
  // Device pins
  output var xpc_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pins = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 4'h0, 5'h00};
  task automatic gap(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : gap
  // Long wait covers the two-flop lag plus decode
  task automatic ctl(input logic cs, input logic upd, input logic md);
    pins.cs_n = cs;
    pins.upd_n = upd;
    pins.mode = md;
    gap(6);
  endtask : ctl
  // Four clocks a phase gives the 320 ns load clock
  task automatic shift_bit(input logic b);
    pins.sin = b;
    gap(4);
    pins.lclk = 1'b0;
    gap(4);
    pins.lclk = 1'b1;
  endtask : shift_bit
  task automatic par_write(input logic [3:0] a, input logic [4:0] d);
    pins.addr = a;
    pins.data = d;
    gap(4);
    pins.lclk = 1'b0;
    gap(4);
    pins.lclk = 1'b1;
    gap(4);
    pins.data = ~d;
    gap(1);
  endtask : par_write
endmodule : xpc_host
`default_nettype wire

//--- testbench/tb.sv
`default_nettype none
module tb
  import xpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic            core_clk;
  logic            rstn;
  logic            serial_out;
  logic [SR_W-1:0] route_image;
  logic [XB_W-1:0] src_enable;
  logic [SR_W-1:0] img_a;
  logic [SR_W-1:0] img_b;
  xpc_pins_t       pins;
  int              n_mismatch;
  int              compares;
  int              cyc;
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  xpc_host i_xpc_host (.core_clk(core_clk), .pins(pins));
  xpc_loader i_xpc_loader (
    .core_clk(core_clk), .rstn(rstn), .chip_sel_n(pins.cs_n),
    .update_n(pins.upd_n), .load_mode_select(pins.mode),
    .load_clk(pins.lclk), .serial_in(pins.sin),
    .select_bit0(pins.data[0]), .select_bit1(pins.data[1]),
    .select_bit2(pins.data[2]), .select_bit3(pins.data[3]),
    .output_enable_bit(pins.data[4]), .out_addr_bit0(pins.addr[0]),
    .out_addr_bit1(pins.addr[1]), .out_addr_bit2(pins.addr[2]),
    .out_addr_bit3(pins.addr[3]), .serial_out(serial_out),
    .route_image(route_image), .src_enable(src_enable));
  task automatic chk(input string what, input logic [XB_W-1:0] seen,
                     input logic [XB_W-1:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  function automatic logic [SR_W-1:0] mk(input int k);
    logic [SR_W-1:0] r;
    for (int o = 0; o < NUM_OUT; o++)
      r[o*SLOT_W+:SLOT_W] = {o != k, 4'(o * k)};
    return r;
  endfunction : mk
  function automatic logic [XB_W-1:0] dec(input logic [SR_W-1:0] img);
    logic [XB_W-1:0] r;
    r = '0;
    for (int o = 0; o < NUM_OUT; o++)
      if (img[o*SLOT_W+EN_POS])
        r[o*NUM_IN+img[o*SLOT_W+:SEL_W]] = 1'b1;
    return r;
  endfunction : dec
  task automatic t_serial();
    i_xpc_host.ctl(1'b0, 1'b1, 1'b0);
    for (int i = SR_W - 1; i >= 0; i--)
      i_xpc_host.shift_bit(img_a[i]);
    chk("held", route_image, '0);
    i_xpc_host.ctl(1'b0, 1'b0, 1'b0);
    chk("serial", route_image, img_a);
    chk("decode a", src_enable, dec(img_a));
    i_xpc_host.ctl(1'b0, 1'b1, 1'b0);
  endtask : t_serial
  task automatic t_chain();
    for (int i = SR_W - 1; i >= 0; i--)
    begin
      i_xpc_host.shift_bit(img_b[i]);
      chk("chain", serial_out, i > 0 ? img_a[i-1] : img_b[SR_W-1]);
    end
    chk("no follow", route_image, img_a);
  endtask : t_chain
  task automatic t_par();
    img_b[3*SLOT_W+:SLOT_W] = 5'h1e;
    img_b[15*SLOT_W+:SLOT_W] = 5'h02;
    i_xpc_host.ctl(1'b1, 1'b0, 1'b1);
    i_xpc_host.par_write(4'h3, 5'h00);
    chk("cs high", route_image, img_a);
    i_xpc_host.ctl(1'b0, 1'b1, 1'b1);
    i_xpc_host.par_write(4'h3, 5'h1e);
    i_xpc_host.par_write(4'hf, 5'h02);
    chk("msb", serial_out, 1'b0);
    i_xpc_host.ctl(1'b0, 1'b0, 1'b1);
    chk("parallel", route_image, img_b);
    chk("decode b", src_enable, dec(img_b));
    i_xpc_host.ctl(1'b0, 1'b1, 1'b1);
  endtask : t_par
  task automatic t_reset();
    #5 rstn = 1'b0;
    #5 chk("reset img", route_image, '0);
    chk("reset dec", src_enable, '0);
    i_xpc_host.gap(3);
    rstn = 1'b1;
    chk("kept msb", serial_out, 1'b0);
    i_xpc_host.ctl(1'b0, 1'b0, 1'b1);
    i_xpc_host.gap(4);
    chk("kept", route_image, img_b);
  endtask : t_reset
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  initial
  begin
    rstn = 1'b0;
    n_mismatch = 0;
    compares = 0;
    cyc = 0;
    img_a = mk(4);
    img_b = mk(7);
    repeat (12) @(posedge core_clk);
    #1 rstn = 1'b1;
    i_xpc_host.gap(4);
    t_serial();
    t_chain();
    t_par();
    t_reset();
    end_sim();
  end
endmodule : tb
`default_nettype wire
